// >>> logic/nfce_defs.svh
`ifndef NFCE_DEFS_SVH
`define NFCE_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define NFCE_CTRL_OFS   8'h00
`define NFCE_ADDR_OFS   8'h04
`define NFCE_WDATA_OFS  8'h08
`define NFCE_RDATA_OFS  8'h0C
`define NFCE_STAT_OFS   8'h10
`define NFCE_PIN_OFS    8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define NFCE_CTRL_OP_LSB   0
`define NFCE_CTRL_OP_MSB   2
`define NFCE_STAT_BUSY     0
`define NFCE_STAT_DONE     1
`define NFCE_STAT_FAIL     2
`define NFCE_STAT_RDY      3
`define NFCE_PIN_VPP       0
`define NFCE_POLL_BIT      7
`define NFCE_ALT_BIT       6
`define NFCE_FAIL_BIT      5
`define NFCE_SUPPLY_BIT    3

// ---------------------------------------------------------------
// Reset values and command codes
// ---------------------------------------------------------------
`define NFCE_ADDR_RST    21'h000000
`define NFCE_DATA_RST    16'h0000
`define NFCE_SEC_CODE    8'h30

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define NFCE_CLK_NS      5
`define NFCE_RST_NS      500
`define NFCE_RST_CYC     ((`NFCE_RST_NS + `NFCE_CLK_NS - 1) / `NFCE_CLK_NS)
`define NFCE_SETUP_CYC   8'h04
`define NFCE_PULSE_CYC   8'h0A
`define NFCE_HOLD_CYC    8'h04
`define NFCE_ACCESS_CYC  8'h12
`define NFCE_RECOV_CYC   8'h20

`endif

// >>> logic/nfce_pkg.sv
package nfce_pkg;

    // Operations that software starts through the control register
    typedef enum logic [2:0] {
        NFCE_OP_READ   = 3'b000,
        NFCE_OP_WRITE  = 3'b001,
        NFCE_OP_SECTOR = 3'b010,
        NFCE_OP_POLL   = 3'b011,
        NFCE_OP_RESET  = 3'b100
    } nfce_op_e;

    // Pin sequencer states
    typedef enum logic [2:0] {
        NFCE_ST_IDLE   = 3'b000,
        NFCE_ST_SETUP  = 3'b001,
        NFCE_ST_PULSE  = 3'b010,
        NFCE_ST_HOLD   = 3'b011,
        NFCE_ST_ACCESS = 3'b100,
        NFCE_ST_RSTLO  = 3'b101,
        NFCE_ST_RECOV  = 3'b110
    } nfce_state_e;

    // Control pins toward the flash
    typedef struct packed {
        logic [20:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        rst_n;
        logic        vpp_en;
    } nfce_pins_s;

    // AHB-Lite request from the master
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } nfce_ahb_s;

endpackage

// >>> logic/nfce_sync.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Two-flop synchroniser, first stage feeds only the second
// ---------------------------------------------------------------
module nfce_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;   // Metastable stage, never read by logic

    // Both stages clear to zero on reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// >>> logic/nfce_ctrl.sv
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "nfce_defs.svh"
module nfce_ctrl (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire nfce_pkg::nfce_ahb_s ahb_in,
    input  wire logic [31:0]         hwdata,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    output nfce_pkg::nfce_pins_s     pins,
    input  wire logic [15:0]         flash_data_in,
    output logic [15:0]              flash_data_out,
    output logic                     flash_data_oe,
    input  wire logic                flash_ready
);
    import nfce_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    nfce_state_e state;          // Pin sequencer state
    nfce_op_e    op;             // Operation in progress
    logic [7:0]  cnt;            // Phase timer
    logic [20:0] addr_reg;       // Target word address
    logic [15:0] wdata_reg;      // Data for write operations
    logic [15:0] rdata_reg;      // Last word read back
    logic        busy;           // Operation running
    logic        busy_q;         // Busy one cycle back, marks its fall
    logic        done;           // Last operation finished
    logic        fail;           // Poll ended on a fault bit
    logic        prev_alt;       // Alternating bit of previous poll read
    logic        have_prev;      // A previous poll read exists
    logic        ph_act;         // AHB data phase pending
    logic        ph_write;       // Pending phase is a write
    logic [7:0]  ph_addr;        // Pending phase offset
    logic        go;             // Accepted start request
    logic [15:0] data_sync;      // Synchronised data bus
    logic        ready_sync;     // Synchronised ready pin
    logic [7:0]  rst_low_cnt;    // Assertion helper: reset width

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    nfce_sync #(.WIDTH(16)) u_data_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in (flash_data_in),
        .sync_out (data_sync)
    );

    nfce_sync #(.WIDTH(1)) u_ready_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in (flash_ready),
        .sync_out (ready_sync)
    );

    // ---------------------------------------------------------------
    // AHB-Lite slave, one wait state per transfer
    // ---------------------------------------------------------------
    // Wait state lets a read see a write made just before it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_act    <= 1'b0;
            ph_write  <= 1'b0;
            ph_addr   <= 8'h00;
            hreadyout <= 1'b1;
        end else if (ph_act) begin
            // Data phase completes
            ph_act    <= 1'b0;
            hreadyout <= 1'b1;
        end else if (ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready) begin
            // Address phase taken
            ph_act    <= 1'b1;
            ph_write  <= ahb_in.hwrite;
            ph_addr   <= ahb_in.haddr[7:0];
            hreadyout <= 1'b0;
        end
    end

    // Response is always OKAY
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Read mux, unmapped offsets read as zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (ph_act && !ph_write) begin
            unique case (ph_addr)
                `NFCE_CTRL_OFS:  hrdata <= {29'h0, op};
                `NFCE_ADDR_OFS:  hrdata <= {11'h0, addr_reg};
                `NFCE_WDATA_OFS: hrdata <= {16'h0, wdata_reg};
                `NFCE_RDATA_OFS: hrdata <= {16'h0, rdata_reg};
                `NFCE_STAT_OFS:  hrdata <= {28'h0, ready_sync, fail, done, busy};
                `NFCE_PIN_OFS:   hrdata <= {31'h0, pins.vpp_en};
                default:         hrdata <= 32'h00000000;
            endcase
        end
    end

    // Start request; ignored while an operation runs
    assign go = ph_act && ph_write && (ph_addr == `NFCE_CTRL_OFS) && !busy;

    // Address and write data registers, frozen while busy
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg  <= `NFCE_ADDR_RST;
            wdata_reg <= `NFCE_DATA_RST;
        end else if (ph_act && ph_write && !busy) begin
            if (ph_addr == `NFCE_ADDR_OFS) begin
                addr_reg <= hwdata[20:0];
            end
            if (ph_addr == `NFCE_WDATA_OFS) begin
                wdata_reg <= hwdata[15:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Supply enable pin
    // ---------------------------------------------------------------
    // Changed only between operations, so a cycle never sees a dip
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins.vpp_en <= 1'b0;
        end else if (ph_act && ph_write && !busy && ph_addr == `NFCE_PIN_OFS) begin
            pins.vpp_en <= hwdata[`NFCE_PIN_VPP];
        end
    end

    // ---------------------------------------------------------------
    // Pin sequencer
    // ---------------------------------------------------------------
    // Write: CE low, WE pulse, WE rise, CE rise; read: CE and OE low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state          <= NFCE_ST_IDLE;
            op             <= NFCE_OP_READ;
            cnt            <= 8'h00;
            busy           <= 1'b0;
            pins.addr      <= `NFCE_ADDR_RST;
            pins.ce_n      <= 1'b1;
            pins.oe_n      <= 1'b1;
            pins.we_n      <= 1'b1;
            pins.rst_n     <= 1'b1;
            flash_data_out <= `NFCE_DATA_RST;
            flash_data_oe  <= 1'b0;
        end else begin
            unique case (state)
                NFCE_ST_IDLE: begin
                    if (go) begin
                        op   <= nfce_op_e'(hwdata[`NFCE_CTRL_OP_MSB:`NFCE_CTRL_OP_LSB]);
                        busy <= 1'b1;
                        cnt  <= 8'h00;
                        pins.addr <= addr_reg;
                        unique case (nfce_op_e'(hwdata[`NFCE_CTRL_OP_MSB:`NFCE_CTRL_OP_LSB]))
                            NFCE_OP_WRITE: begin
                                // Enable first so address latches at WE fall
                                pins.ce_n      <= 1'b0;
                                flash_data_out <= wdata_reg;
                                state          <= NFCE_ST_SETUP;
                            end
                            NFCE_OP_SECTOR: begin
                                // Final cycle of the erase sequence
                                pins.ce_n      <= 1'b0;
                                flash_data_out <= {8'h00, `NFCE_SEC_CODE};
                                state          <= NFCE_ST_SETUP;
                            end
                            NFCE_OP_READ, NFCE_OP_POLL: begin
                                pins.ce_n <= 1'b0;
                                pins.oe_n <= 1'b0;
                                state     <= NFCE_ST_ACCESS;
                            end
                            NFCE_OP_RESET: begin
                                pins.rst_n <= 1'b0;
                                state      <= NFCE_ST_RSTLO;
                            end
                            default: begin
                                // Unknown code finishes at once
                                busy  <= 1'b0;
                                state <= NFCE_ST_IDLE;
                            end
                        endcase
                    end
                end
                NFCE_ST_SETUP: begin
                    // OE stays high while the data bus is driven
                    flash_data_oe <= pins.oe_n;
                    cnt <= cnt + 8'h01;
                    if (cnt == `NFCE_SETUP_CYC) begin
                        pins.we_n <= 1'b0;
                        cnt       <= 8'h00;
                        state     <= NFCE_ST_PULSE;
                    end
                end
                NFCE_ST_PULSE: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == `NFCE_PULSE_CYC) begin
                        // Data latched here, so data still driven
                        pins.we_n <= 1'b1;
                        cnt       <= 8'h00;
                        state     <= NFCE_ST_HOLD;
                    end
                end
                NFCE_ST_HOLD: begin
                    cnt <= cnt + 8'h01;
                    if (cnt == `NFCE_HOLD_CYC) begin
                        pins.ce_n     <= 1'b1;
                        flash_data_oe <= 1'b0;
                        busy          <= 1'b0;
                        state         <= NFCE_ST_IDLE;
                    end
                end
                NFCE_ST_ACCESS: begin
                    // Access time plus the two synchroniser stages
                    cnt <= cnt + 8'h01;
                    if (cnt == `NFCE_ACCESS_CYC) begin
                        pins.oe_n <= 1'b1;
                        pins.ce_n <= 1'b1;
                        cnt       <= 8'h00;
                        if (op == NFCE_OP_POLL && !poll_end(data_sync)) begin
                            state <= NFCE_ST_RECOV;
                        end else begin
                            busy  <= 1'b0;
                            state <= NFCE_ST_IDLE;
                        end
                    end
                end
                NFCE_ST_RSTLO: begin
                    // Long enough to also leave single-pulse mode
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(`NFCE_RST_CYC - 1)) begin
                        pins.rst_n <= 1'b1;
                        cnt        <= 8'h00;
                        state      <= NFCE_ST_RECOV;
                    end
                end
                NFCE_ST_RECOV: begin
                    // Gap after reset or between poll reads
                    cnt <= cnt + 8'h01;
                    if (cnt == `NFCE_RECOV_CYC) begin
                        cnt <= 8'h00;
                        if (op == NFCE_OP_POLL) begin
                            pins.ce_n <= 1'b0;
                            pins.oe_n <= 1'b0;
                            state     <= NFCE_ST_ACCESS;
                        end else begin
                            busy  <= 1'b0;
                            state <= NFCE_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= NFCE_ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Poll decision
    // ---------------------------------------------------------------
    // Ends when the alternating bit stops, or fault bits show on two reads in a row;
    // true data may carry those bits, so a single read is not trusted
    function automatic logic poll_end(input logic [15:0] d);
        poll_end = have_prev && ((d[`NFCE_ALT_BIT] == prev_alt) ||
                   ((d[`NFCE_FAIL_BIT] || d[`NFCE_SUPPLY_BIT]) &&
                    (rdata_reg[`NFCE_FAIL_BIT] || rdata_reg[`NFCE_SUPPLY_BIT])));
    endfunction

    // Read capture and poll bookkeeping
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= `NFCE_DATA_RST;
            prev_alt  <= 1'b0;
            have_prev <= 1'b0;
        end else if (go) begin
            have_prev <= 1'b0;
        end else if (state == NFCE_ST_ACCESS && cnt == `NFCE_ACCESS_CYC) begin
            rdata_reg <= data_sync;
            prev_alt  <= data_sync[`NFCE_ALT_BIT];
            have_prev <= 1'b1;
        end
    end

    // Done and fail flags; a new start clears them
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            done   <= 1'b0;
            fail   <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
            if (go) begin
                done <= 1'b0;
                fail <= 1'b0;
            end else if (state == NFCE_ST_ACCESS && cnt == `NFCE_ACCESS_CYC && op == NFCE_OP_POLL) begin
                if (poll_end(data_sync)) begin
                    done <= 1'b1;
                    // Fault only while toggling; software must then send the exit command
                    fail <= !(have_prev && data_sync[`NFCE_ALT_BIT] == prev_alt);
                end
            end else if (busy) begin
                done <= 1'b0;
            end else if (busy_q) begin
                done <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertion helpers and assertions
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_low_cnt <= 8'h00;
        end else if (!pins.rst_n) begin
            rst_low_cnt <= rst_low_cnt + 8'h01;
        end else begin
            rst_low_cnt <= 8'h00;
        end
    end

    drive_oe_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        flash_data_oe |-> pins.oe_n && !pins.ce_n)
        else $error("data driven while output enable low");

    we_ce_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !pins.we_n |-> !pins.ce_n && pins.oe_n && flash_data_oe)
        else $error("write strobe without chip enable");

    we_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !pins.we_n |=> $stable(pins.addr) && $stable(flash_data_out))
        else $error("address or data moved during write pulse");

    we_width_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(pins.we_n) |-> !pins.we_n[*8])
        else $error("write pulse too short");

    sec_code_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op == NFCE_OP_SECTOR && !pins.we_n) |-> flash_data_out[7:0] == `NFCE_SEC_CODE)
        else $error("sector erase cycle lacks erase code");

    rst_width_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(pins.rst_n) |-> $past(rst_low_cnt) >= 8'(`NFCE_RST_CYC - 1))
        else $error("flash reset pulse too short");

    rst_end_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(pins.rst_n) |-> ##[1:120] pins.rst_n)
        else $error("flash reset held too long");

    vpp_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        busy |=> $stable(pins.vpp_en))
        else $error("supply enable moved during operation");

    start_busy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (go && hwdata[2:0] <= 3'b100) |=> busy && state != NFCE_ST_IDLE)
        else $error("start request not taken");
endmodule

// >>> logic/dummy_placeholder_removed.sv
`timescale 1ns/10ps

// >>> sim/nfce_flash_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Flash in single-pulse mode: each write pulse with the supply enabled, taken while no program runs, programs one word unless a reset aborts it
// ---------------------------------------------------------------
module nfce_flash_model #(
    parameter int BUSY_CYC = 150
) (
    input  wire logic                 core_clk,
    input  wire nfce_pkg::nfce_pins_s pins,
    input  wire logic [15:0]          dq_in,
    output logic      [15:0]          dq_out,
    output logic                      dq_oe,
    output logic                      ready
);
    import nfce_pkg::*;
    logic [15:0] mem [0:255]; // Upper address bits alias onto this window
    logic [15:0] loaded;      // Last word loaded
    logic [7:0]  waddr;       // Target of the running program
    logic        we_q;        // Strobe one cycle back
    logic        fault;       // Supply fault, held until reset or the next write strobe
    logic        alt = 1'b0;  // Alternating status bit
    int          cnt = 0;     // Internal timebase
    wire         status = (cnt > 0) || fault;
    localparam logic [1:0] STAT_CFG = 2'b00;  // Power-up value, no command changes it here
    wire         poll_bit = (STAT_CFG == 2'b01) ? 1'b0 : ~loaded[7];
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
        fault = 1'b0;
        loaded = 16'h0000;
        waddr = 8'h00;
    end
    // Program on strobe rise; sector code is just data in this mode,
    // so no command byte is decoded and no erase or lockdown starts
    always @(posedge core_clk) begin
        we_q <= pins.we_n;
        if (!pins.rst_n) begin
            if (cnt > 0) mem[waddr] <= 16'hXXXX;
            cnt <= 0;
            fault <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) mem[waddr] <= mem[waddr] & loaded;
        end else if (pins.we_n && !we_q && !pins.ce_n && pins.oe_n) begin
            loaded <= dq_in;
            waddr <= pins.addr[7:0];
            cnt <= pins.vpp_en ? BUSY_CYC : 0;
            fault <= !pins.vpp_en;
        end
    end
    // Status toggles once per completed read, only while a program runs or a fault is held
    always @(posedge pins.oe_n) if (status) alt <= !alt;
    assign dq_oe = pins.rst_n && !pins.ce_n && !pins.oe_n && pins.we_n;
    assign dq_out = status ? {8'h00, poll_bit, alt, fault, 1'b0, fault, 3'h0}
                           : mem[pins.addr[7:0]];
    assign ready = (cnt == 0);
endmodule

// >>> sim/nor_flash_command_engine_tb.sv
`timescale 1ns/10ps
`include "nfce_defs.svh"
module nor_flash_command_engine_tb;
    import nfce_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        sel = 1'b0;       // Address phase fields
    logic [7:0]  ofs = 8'h00;
    logic [1:0]  trans = 2'h0;
    logic        wr = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, fl_oe, mdl_oe, fl_ready;
    nfce_ahb_s   ahb_in;
    nfce_pins_s  pins;
    logic [15:0] bus, fl_out, mdl_dq;
    logic [15:0] last_dq = 16'h0;
    logic [15:0] shadow [0:255];   // Expected array
    logic [7:0]  a;
    logic [2:0]  c;
    logic [15:0] d;
    int          errors = 0;
    int          tests_run = 0;
    always #2.5 core_clk = ~core_clk;
    assign ahb_in = {sel, 24'h0, ofs, trans, wr, 3'h2, hreadyout};
    // A released bus must not keep its last value
    assign bus = fl_oe ? fl_out : (mdl_oe ? mdl_dq : ~last_dq);
    always @(posedge core_clk) if (fl_oe || mdl_oe) last_dq <= bus;
    nfce_ctrl dut (.core_clk(core_clk), .reset_n(reset_n), .ahb_in(ahb_in), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .flash_data_in(bus),
        .flash_data_out(fl_out), .flash_data_oe(fl_oe), .flash_ready(fl_ready));
    nfce_flash_model #(.BUSY_CYC(150)) flash (.core_clk(core_clk), .pins(pins), .dq_in(bus),
        .dq_out(mdl_dq), .dq_oe(mdl_oe), .ready(fl_ready));
    // Expected word after a program or a sector-code write
    function automatic logic [15:0] exp_word(input logic [15:0] old, input logic [2:0] op,
                                             input logic [15:0] dat);
        return old & ((op == 3'h2) ? 16'h0030 : dat);
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic ready_edge();
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (hreadyout === 1'b1) return;
        end
        $display("timeout on bus");
        errors++;
        print_verdict();
    endtask
    task automatic xfer(input logic w, input logic [7:0] o, input logic [31:0] dat);
        sel <= 1'b1;
        ofs <= o;
        wr <= w;
        trans <= 2'h2;
        ready_edge();
        sel <= 1'b0;
        trans <= 2'h0;
        hwdata <= dat;
        ready_edge();
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e);
        tests_run++;
        if (rd !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, rd);
            errors++;
        end
    endtask
    // Start an operation and poll the status until it ends
    task automatic op(input logic [2:0] code);
        xfer(1'b1, `NFCE_CTRL_OFS, {29'h0, code});
        for (int i = 0; i < 400; i++) begin
            xfer(1'b0, `NFCE_STAT_OFS, 32'h0);
            if (rd[0] === 1'b0 && rd[1] === 1'b1) return;
        end
        $display("timeout on operation");
        errors++;
        print_verdict();
    endtask
    task automatic prog_word(input logic [7:0] adr, input logic [2:0] code, input logic [15:0] dat);
        xfer(1'b1, `NFCE_ADDR_OFS, {24'h0, adr});
        xfer(1'b1, `NFCE_WDATA_OFS, {16'h0, dat});
        op(code);
    endtask
    initial begin
        void'($urandom(32'h041e9e83));
        for (int i = 0; i < 256; i++) shadow[i] = 16'hFFFF;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        xfer(1'b0, `NFCE_STAT_OFS, 32'h0);
        chk("stat_reset", 32'h8);
        xfer(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h0);
        xfer(1'b1, `NFCE_PIN_OFS, 32'h1);
        $display("test reset done");
        // First words hit one address so bits can only clear
        for (int n = 0; n < 12; n++) begin
            a = (n < 4) ? 8'h05 : 8'($urandom);
            c = (n % 3 == 2) ? 3'h2 : 3'h1;
            d = 16'($urandom);
            prog_word(a, c, d);
            chk("stat_busy", 32'h2);
            shadow[a] = exp_word(shadow[a], c, d);
            op(3'h3);
            chk("stat_poll", 32'hA);
            op(3'h0);
            xfer(1'b0, `NFCE_RDATA_OFS, 32'h0);
            chk("word", {16'h0, shadow[a]});
        end
        $display("test program done");
        xfer(1'b1, `NFCE_PIN_OFS, 32'h0);
        prog_word(8'h05, 3'h1, 16'h0000);
        op(3'h3);
        chk("stat_fault", 32'hE);
        op(3'h4);
        op(3'h0);
        xfer(1'b0, `NFCE_RDATA_OFS, 32'h0);
        chk("word_kept", {16'h0, shadow[8'h05]});
        $display("test supply done");
        xfer(1'b1, `NFCE_PIN_OFS, 32'h1);
        prog_word(8'h21, 3'h1, 16'h1234);
        op(3'h4);
        chk("stat_abort", 32'hA);
        $display("test abort done");
        print_verdict();
    end
endmodule
